// File: verilog/system_bus_address_phase.sv
// system end of the address phase: straps, float, snoop issue, cycle watch
`timescale 1ns/1ps
`default_nettype none
module system_bus_address_phase
    import bus_addr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // pins
    bus_addr_if.host pins,
    // static controls
    input wire logic wrap_enable,
    input wire logic float_hold,
    input wire logic strap_irq_enable,
    input wire logic [ID_WIDTH-1:0] strap_id,
    // snoop request
    input wire logic snoop_req,
    output logic snoop_ready,
    input wire logic [ADDR_MSB:SNOOP_LSB] snoop_req_addr,
    input wire logic snoop_corrupt,
    // observed processor cycles
    output logic cycle_valid,
    output logic [ADDR_MSB:ADDR_LSB] cycle_addr,
    output logic [BE_WIDTH-1:0] cycle_be,
    output logic cycle_parity_error,
    output logic parity_error_seen
);
    typedef struct packed {
        logic ads_s1;
        logic ads_s2;
        logic perr_s1;
        logic perr_s2;
        logic [ADDR_MSB:ADDR_LSB] addr_s1;
        logic [ADDR_MSB:ADDR_LSB] addr_s2;
        logic ap_s1;
        logic ap_s2;
        logic [BE_WIDTH-1:0] be_s1;
        logic [BE_WIDTH-1:0] be_s2;
        host_state_type state;
        logic [2:0] cnt;
        logic [ADDR_MSB:SNOOP_LSB] snp_addr;
        logic snp_corrupt;
        logic [ADDR_MSB:ADDR_LSB] addr_out;
        logic ap_out;
        logic addr_oe_n;
        logic [BE_BIDIR-1:0] be_out;
        logic be_oe_n;
        logic external_snoop_strobe_n_n;
        logic wrap_n;
        logic float_req;
        logic irq_out;
        logic cycle_valid;
        logic [ADDR_MSB:ADDR_LSB] cycle_addr;
        logic [BE_WIDTH-1:0] cycle_be;
        logic cycle_perr;
        logic perr_seen;
    } host_regs_type;

    host_regs_type r;
    host_regs_type next_r;

    assign snoop_ready = (r.state == HOST_IDLE);

    // next state
    always_comb begin
        next_r = r;
        next_r.ads_s1 = pins.cycle_start_strobe_n;
        next_r.ads_s2 = r.ads_s1;
        next_r.perr_s1 = pins.address_parity_error_n;
        next_r.perr_s2 = r.perr_s1;
        next_r.addr_s1 = pins.phys_address_bus;
        next_r.addr_s2 = r.addr_s1;
        next_r.ap_s1 = pins.address_parity_bit;
        next_r.ap_s2 = r.ap_s1;
        next_r.be_s1 = pins.byte_lane_enable_n;
        next_r.be_s2 = r.be_s1;
        next_r.external_snoop_strobe_n_n = 1'b1;
        // mask only asked for by real-mode software
        next_r.wrap_n = !wrap_enable;
        next_r.irq_out = strap_irq_enable;
        case (r.state)
            HOST_STRAP: begin
                next_r.be_oe_n = 1'b0;
                next_r.be_out = {1'b1, strap_id};
                next_r.cnt = r.cnt + 3'h1;
                if (r.cnt == STRAP_HOLD) begin
                    next_r.be_oe_n = 1'b1;
                    next_r.cnt = 3'h0;
                    next_r.state = HOST_IDLE;
                end
            end
            HOST_IDLE: begin
                if (snoop_req) begin
                    next_r.snp_addr = snoop_req_addr;
                    next_r.snp_corrupt = snoop_corrupt;
                    next_r.cnt = 3'h0;
                    next_r.state = HOST_FLOAT;
                end
            end
            HOST_FLOAT: begin
                next_r.cnt = r.cnt + 3'h1;
                if (r.cnt == FLOAT_SETTLE) begin
                    next_r.addr_out = {r.snp_addr, 2'b00};
                    next_r.ap_out = even_parity({r.snp_addr, 2'b00}) ^ r.snp_corrupt;
                    next_r.addr_oe_n = 1'b0;
                    next_r.external_snoop_strobe_n_n = 1'b0;
                    next_r.state = HOST_SNOOP;
                end
            end
            HOST_SNOOP: begin
                next_r.addr_oe_n = 1'b1;
                next_r.state = HOST_IDLE;
            end
            default: begin
                next_r.state = HOST_IDLE;
            end
        endcase
        next_r.float_req = float_hold || (next_r.state == HOST_FLOAT) || (next_r.state == HOST_SNOOP);
        next_r.cycle_valid = !r.ads_s2;
        if (!r.ads_s2) begin
            next_r.cycle_addr = r.addr_s2;
            next_r.cycle_be = ~r.be_s2;
            next_r.cycle_perr = even_parity(r.addr_s2) != r.ap_s2;
        end
        next_r.perr_seen = !r.perr_s2;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            r <= '0;
            r.ads_s1 <= 1'b1;
            r.ads_s2 <= 1'b1;
            r.perr_s1 <= 1'b1;
            r.perr_s2 <= 1'b1;
            r.be_s1 <= BE_IDLE_N;
            r.be_s2 <= BE_IDLE_N;
            r.state <= HOST_STRAP;
            r.addr_out <= ADDR_RESET;
            r.addr_oe_n <= 1'b1;
            // straps stand on the pins while reset is held
            r.irq_out <= strap_irq_enable;
            r.be_out <= {1'b1, strap_id};
            r.be_oe_n <= 1'b0;
            r.external_snoop_strobe_n_n <= 1'b1;
            r.wrap_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // pin drive
    assign pins.address_wrap_mask_n = r.wrap_n;
    assign pins.address_float_request = r.float_req;
    assign pins.external_snoop_strobe_n = r.external_snoop_strobe_n_n;
    assign pins.irq_bus_data_1 = r.irq_out;
    assign pins.host_addr_out = r.addr_out;
    assign pins.host_addr_oe_n = r.addr_oe_n;
    assign pins.host_ap_out = r.ap_out;
    assign pins.host_ap_oe_n = r.addr_oe_n;
    assign pins.host_be_out = r.be_out;
    assign pins.host_be_oe_n = r.be_oe_n;

    // observation outputs
    assign cycle_valid = r.cycle_valid;
    assign cycle_addr = r.cycle_addr;
    assign cycle_be = r.cycle_be;
    assign cycle_parity_error = r.cycle_perr;
    assign parity_error_seen = r.perr_seen;
endmodule
`default_nettype wire

// File: verilog/bus_addr_pkg.sv
// shared constants, types and helpers for the address-phase ends
// Summary of operation
// - wrap mask forces address bit 20 low
// - host asserts wrap mask only in real mode
// - address lines plus byte enables locate access
// - host drives snoop address on bits 31:5
// - cycle-start strobe marks each new cycle
// - float request releases address and parity next clock; the code releases them on the third clock after the request rises
// - even address parity driven with the address
// - host drives even parity with snoop strobe; the code inverts it when snoop_corrupt is set
// - parity error pulses two clocks after strobe; the code pulses it four clocks after the strobe
// - interrupt controller enable strap sampled at reset
// - byte enables driven with address, low five bidirectional
// - low four byte enables captured as id
// - names ending _n are active low
`default_nettype none
package bus_addr_pkg;
    localparam int ADDR_MSB = 31;
    localparam int ADDR_LSB = 3;
    localparam int SNOOP_LSB = 5;
    localparam int WRAP_BIT = 20;
    localparam int BE_WIDTH = 8;
    localparam int BE_BIDIR = 5;
    localparam int ID_WIDTH = 4;
    // cycles after reset release before straps are caught
    localparam logic [2:0] STRAP_SETTLE = 3'h2;
    // cycles the host keeps straps driven after reset release
    localparam logic [2:0] STRAP_HOLD = 3'h6;
    // cycles between float request and driving a snoop address
    localparam logic [2:0] FLOAT_SETTLE = 3'h4;
    localparam logic [ADDR_MSB:ADDR_LSB] ADDR_RESET = 29'h0000_0000;
    localparam logic [BE_WIDTH-1:0] BE_IDLE_N = 8'hff;

    typedef enum logic [1:0] {
        DEV_STRAP = 2'b00,
        DEV_RUN = 2'b01
    } dev_state_type;

    typedef enum logic [1:0] {
        HOST_STRAP = 2'b00,
        HOST_IDLE = 2'b01,
        HOST_FLOAT = 2'b10,
        HOST_SNOOP = 2'b11
    } host_state_type;

    // even parity bit over the driven address
    function automatic logic even_parity(input logic [ADDR_MSB:ADDR_LSB] addr);
        even_parity = ^addr;
    endfunction
endpackage
`default_nettype wire

// File: verilog/bus_addr_if.sv
// pin-level carrier joining the processor end and the system end
`timescale 1ns/1ps
`default_nettype none
interface bus_addr_if;
    import bus_addr_pkg::*;
    // system to processor
    logic address_wrap_mask_n;
    logic address_float_request;
    logic external_snoop_strobe_n;
    logic irq_bus_data_1;
    // processor to system
    logic cycle_start_strobe_n;
    logic address_parity_error_n;
    // address lines, both drivers
    logic [ADDR_MSB:ADDR_LSB] dev_addr_out;
    logic dev_addr_oe_n;
    logic [ADDR_MSB:ADDR_LSB] host_addr_out;
    logic host_addr_oe_n;
    logic [ADDR_MSB:ADDR_LSB] phys_address_bus;
    // parity line, both drivers
    logic dev_ap_out;
    logic dev_ap_oe_n;
    logic host_ap_out;
    logic host_ap_oe_n;
    logic address_parity_bit;
    // byte enables: top three output only, low five two-way
    logic [BE_WIDTH-1:0] dev_be_out;
    logic dev_be_oe_n;
    logic [BE_BIDIR-1:0] host_be_out;
    logic host_be_oe_n;
    logic [BE_WIDTH-1:0] byte_lane_enable_n;

    // wire resolution, undriven lines pull high
    assign phys_address_bus = !dev_addr_oe_n ? dev_addr_out : (!host_addr_oe_n ? host_addr_out : '1);
    assign address_parity_bit = !dev_ap_oe_n ? dev_ap_out : (!host_ap_oe_n ? host_ap_out : 1'b1);
    assign byte_lane_enable_n[BE_WIDTH-1:BE_BIDIR] = dev_be_out[BE_WIDTH-1:BE_BIDIR];
    assign byte_lane_enable_n[BE_BIDIR-1:0] = !dev_be_oe_n ? dev_be_out[BE_BIDIR-1:0] :
                                              (!host_be_oe_n ? host_be_out : '1);

    modport device (
        input address_wrap_mask_n, address_float_request, external_snoop_strobe_n, irq_bus_data_1,
        input phys_address_bus, address_parity_bit, byte_lane_enable_n,
        output cycle_start_strobe_n, address_parity_error_n,
        output dev_addr_out, dev_addr_oe_n, dev_ap_out, dev_ap_oe_n, dev_be_out, dev_be_oe_n
    );
    modport host (
        output address_wrap_mask_n, address_float_request, external_snoop_strobe_n, irq_bus_data_1,
        input phys_address_bus, address_parity_bit, byte_lane_enable_n,
        input cycle_start_strobe_n, address_parity_error_n,
        output host_addr_out, host_addr_oe_n, host_ap_out, host_ap_oe_n, host_be_out, host_be_oe_n
    );
endinterface
`default_nettype wire

// File: verilog/cpu_bus_address_phase.sv
// processor end of the address phase: cycles, float, parity, snoop check, straps
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_address_phase
    import bus_addr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // pins
    bus_addr_if.device pins,
    // cycle request from the core
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [ADDR_MSB:ADDR_LSB] req_addr,
    input wire logic [BE_WIDTH-1:0] req_be,
    // snoop report
    output logic snoop_valid,
    output logic [ADDR_MSB:SNOOP_LSB] snoop_addr,
    output logic snoop_parity_error,
    // strap results
    output logic straps_valid,
    output logic local_irq_ctrl_enable,
    output logic [ID_WIDTH-1:0] local_irq_ctrl_id
);
    typedef struct packed {
        // pin synchronisers
        logic [ADDR_MSB:ADDR_LSB] addr_s1;
        logic [ADDR_MSB:ADDR_LSB] addr_s2;
        logic ap_s1;
        logic ap_s2;
        logic [ID_WIDTH-1:0] be_s1;
        logic [ID_WIDTH-1:0] be_s2;

        logic float_s1;
        logic float_s2;
        logic wrap_s1;
        logic wrap_s2;
        logic snoop_s1;
        logic snoop_s2;
        logic irq_s1;
        logic irq_s2;

        // strap capture
        dev_state_type state;
        logic [2:0] strap_cnt;
        logic straps_valid;
        logic irq_ctrl_en;
        logic [ID_WIDTH-1:0] irq_ctrl_id;

        // cycle drive
        logic [ADDR_MSB:ADDR_LSB] addr_out;
        logic [BE_WIDTH-1:0] be_out;
        logic ap_out;
        logic ads_n;
        logic addr_oe_n;
        logic be_oe_n;

        // snoop check
        logic perr_stage;
        logic perr_n;
        logic snoop_valid;
        logic [ADDR_MSB:SNOOP_LSB] snoop_addr;
    } dev_regs_type;

    dev_regs_type r;
    dev_regs_type next_r;
    logic [ADDR_MSB:ADDR_LSB] masked_addr;

    // request accepted only while address and lane lines are ours
    assign req_ready = (r.state == DEV_RUN) && !r.float_s2 && !r.addr_oe_n && !r.be_oe_n;

    // next state
    always_comb begin
        next_r = r;
        masked_addr = req_addr;
        // two-flop synchronisers for every pin input except byte enable lanes 7:4, which are not captured
        next_r.addr_s1 = pins.phys_address_bus;
        next_r.addr_s2 = r.addr_s1;
        next_r.ap_s1 = pins.address_parity_bit;
        next_r.ap_s2 = r.ap_s1;

        // strap lanes
        next_r.be_s1 = pins.byte_lane_enable_n[ID_WIDTH-1:0];
        next_r.be_s2 = r.be_s1;

        // control pins
        next_r.float_s1 = pins.address_float_request;
        next_r.float_s2 = r.float_s1;
        next_r.wrap_s1 = pins.address_wrap_mask_n;
        next_r.wrap_s2 = r.wrap_s1;

        // snoop strobe
        next_r.snoop_s1 = pins.external_snoop_strobe_n;
        next_r.snoop_s2 = r.snoop_s1;

        // strap pin
        next_r.irq_s1 = pins.irq_bus_data_1;
        next_r.irq_s2 = r.irq_s1;

        // strobes idle by default
        next_r.ads_n = 1'b1;
        next_r.snoop_valid = 1'b0;
        case (r.state)
            DEV_STRAP: begin
                if (r.strap_cnt == STRAP_SETTLE) begin
                    next_r.irq_ctrl_en = r.irq_s2;
                    next_r.irq_ctrl_id = r.be_s2;
                    next_r.straps_valid = 1'b1;
                    next_r.addr_oe_n = r.float_s2;
                    next_r.ap_out = even_parity(r.addr_out);
                    next_r.state = DEV_RUN;
                end else begin
                    next_r.strap_cnt = r.strap_cnt + 3'h1;
                end
            end
            DEV_RUN: begin
                // lanes wait for the host to drop its straps
                if (r.strap_cnt > STRAP_HOLD) begin
                    next_r.be_oe_n = 1'b0;
                end else begin
                    next_r.strap_cnt = r.strap_cnt + 3'h1;
                end

                // release address and parity on the third clock after the float request rises
                next_r.addr_oe_n = r.float_s2;
                if (req_valid && req_ready) begin
                    if (!r.wrap_s2) begin
                        masked_addr[WRAP_BIT] = 1'b0;
                    end
                    next_r.addr_out = masked_addr;
                    next_r.be_out = ~req_be;
                    next_r.ap_out = even_parity(masked_addr);
                    next_r.ads_n = 1'b0;
                end
            end
            default: begin
                next_r.state = DEV_STRAP;
            end
        endcase

        // error pulse four clocks after strobe
        next_r.perr_stage = (r.state == DEV_RUN) && !r.snoop_s2 && (even_parity(r.addr_s2) != r.ap_s2);
        next_r.perr_n = !r.perr_stage;

        if ((r.state == DEV_RUN) && !r.snoop_s2) begin
            next_r.snoop_valid = 1'b1;
            next_r.snoop_addr = r.addr_s2[ADDR_MSB:SNOOP_LSB];
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            r <= '0;
            // synchronisers idle
            r.addr_s1 <= ADDR_RESET;
            r.addr_s2 <= ADDR_RESET;
            r.be_s1 <= '1;
            r.be_s2 <= '1;
            r.wrap_s1 <= 1'b1;
            r.wrap_s2 <= 1'b1;
            r.snoop_s1 <= 1'b1;
            r.snoop_s2 <= 1'b1;

            // pins released
            r.state <= DEV_STRAP;
            r.addr_out <= ADDR_RESET;
            r.be_out <= BE_IDLE_N;
            r.ads_n <= 1'b1;
            r.addr_oe_n <= 1'b1;
            r.be_oe_n <= 1'b1;
            r.perr_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // pin drive
    assign pins.dev_addr_out = r.addr_out;
    assign pins.dev_addr_oe_n = r.addr_oe_n;
    assign pins.dev_ap_out = r.ap_out;
    assign pins.dev_ap_oe_n = r.addr_oe_n;
    assign pins.dev_be_out = r.be_out;
    assign pins.dev_be_oe_n = r.be_oe_n;

    // active-low strobes
    assign pins.cycle_start_strobe_n = r.ads_n;
    assign pins.address_parity_error_n = r.perr_n;

    // user outputs
    assign snoop_valid = r.snoop_valid;
    assign snoop_addr = r.snoop_addr;
    assign snoop_parity_error = !r.perr_n;

    // strap results
    assign straps_valid = r.straps_valid;
    assign local_irq_ctrl_enable = r.irq_ctrl_en;
    assign local_irq_ctrl_id = r.irq_ctrl_id;
endmodule
`default_nettype wire

// File: tb/bus_addr_chk.sv
// assertions on the address-phase wires between the processor and system ends
`timescale 1ns/1ps
`default_nettype none
module bus_addr_chk
    import bus_addr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // strobes and requests
    input wire logic address_wrap_mask_n,
    input wire logic address_float_request,
    input wire logic external_snoop_strobe_n,
    input wire logic cycle_start_strobe_n,
    input wire logic address_parity_error_n,
    // device drivers and resolved lines
    input wire logic [ADDR_MSB:ADDR_LSB] dev_addr_out,
    input wire logic dev_addr_oe_n,
    input wire logic dev_ap_out,
    input wire logic dev_ap_oe_n,
    input wire logic [BE_WIDTH-1:0] dev_be_out,
    input wire logic dev_be_oe_n,
    input wire logic [ADDR_MSB:ADDR_LSB] phys_address_bus,
    input wire logic address_parity_bit,
    input wire logic [BE_WIDTH-1:0] byte_lane_enable_n
);
    logic wire_bad;
    logic [3:0] run_cnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // parity mismatch on the wires
    assign wire_bad = (^phys_address_bus) != address_parity_bit;
    // cycles since reset release, saturating
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            run_cnt <= 4'h0;
        end else if (run_cnt != 4'hf) begin
            run_cnt <= run_cnt + 4'h1;
        end
    end
    // cycle drive, masking and parity
    property p_wrap;
        !cycle_start_strobe_n && !$past(address_wrap_mask_n, 2) && !$past(address_wrap_mask_n, 3)
            && !$past(address_wrap_mask_n, 4) |-> !dev_addr_out[WRAP_BIT];
    endproperty
    a_wrap: assert property (p_wrap) else $error("address bit 20 not masked");
    property p_drive;
        !cycle_start_strobe_n |-> !dev_addr_oe_n && !dev_be_oe_n && phys_address_bus == dev_addr_out
            && byte_lane_enable_n == dev_be_out;
    endproperty
    a_drive: assert property (p_drive) else $error("cycle strobe without driven lines");
    property p_ap_gen;
        !cycle_start_strobe_n |-> !dev_ap_oe_n && dev_ap_out == ^dev_addr_out;
    endproperty
    a_ap_gen: assert property (p_ap_gen) else $error("parity not even with cycle");
    property p_ap_wire;
        !dev_addr_oe_n && !dev_ap_oe_n |-> !wire_bad;
    endproperty
    a_ap_wire: assert property (p_ap_wire) else $error("driven parity disagrees with lines");
    // float handling
    property p_float_off;
        $rose(address_float_request) ##1 address_float_request [*2] |=> dev_addr_oe_n && dev_ap_oe_n;
    endproperty
    a_float_off: assert property (p_float_off) else $error("address not floated in time");
    property p_float_stay;
        address_float_request [*4] |-> dev_addr_oe_n && dev_ap_oe_n;
    endproperty
    a_float_stay: assert property (p_float_stay) else $error("address driven during float");
    property p_float_back;
        $fell(address_float_request) ##1 !address_float_request [*2] |=> !dev_addr_oe_n && !dev_ap_oe_n;
    endproperty
    a_float_back: assert property (p_float_back) else $error("address not driven after float");
    // snoop parity report
    property p_perr_cause;
        !address_parity_error_n |-> !$past(external_snoop_strobe_n, 4) && $past(wire_bad, 4);
    endproperty
    a_perr_cause: assert property (p_perr_cause) else $error("parity error without bad snoop");
    property p_perr_fire;
        !external_snoop_strobe_n && wire_bad && run_cnt > 4'h8 |-> ##4 !address_parity_error_n
            ##1 address_parity_error_n;
    endproperty
    a_perr_fire: assert property (p_perr_fire) else $error("parity error not one pulse");
    // main scenarios reached
    c_back: cover property (!cycle_start_strobe_n ##1 !cycle_start_strobe_n);
    c_wrap: cover property (!cycle_start_strobe_n && !address_wrap_mask_n);
    c_float: cover property (address_float_request [*4]);
    c_perr: cover property (!address_parity_error_n);
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench joining both address-phase ends on one carrier
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bus_addr_pkg::*;
;
    logic sys_clk, resetn, req_valid, req_ready, wrap_enable, float_hold, strap_irq_enable, snoop_req;
    logic snoop_ready, snoop_corrupt, snoop_valid, snoop_parity_error, straps_valid, local_irq_ctrl_enable;
    logic cycle_valid, cycle_parity_error, parity_error_seen, wrap_on, perr_due;
    logic [ADDR_MSB:ADDR_LSB] req_addr, cycle_addr, a;
    logic [BE_WIDTH-1:0] req_be, cycle_be;
    logic [ADDR_MSB:SNOOP_LSB] snoop_req_addr, snoop_addr;
    logic [ID_WIDTH-1:0] strap_id, local_irq_ctrl_id;
    logic [31:0] r;
    logic [ADDR_MSB:ADDR_LSB] cyc_addr_q[$];
    logic [BE_WIDTH-1:0] cyc_be_q[$];
    logic [ADDR_MSB:SNOOP_LSB] snp_addr_q[$];
    logic snp_bad_q[$];
    int err_count, check_count, perr_sent, perr_seen, seed, n;

    // both ends and the checker on one carrier
    bus_addr_if pins_if();
    cpu_bus_address_phase cpu_bus_address_phase_inst(.sys_clk, .resetn, .pins(pins_if), .req_valid, .req_ready,
        .req_addr, .req_be, .snoop_valid, .snoop_addr, .snoop_parity_error, .straps_valid, .local_irq_ctrl_enable,
        .local_irq_ctrl_id);
    system_bus_address_phase system_bus_address_phase_inst(.sys_clk, .resetn, .pins(pins_if), .wrap_enable,
        .float_hold, .strap_irq_enable, .strap_id, .snoop_req, .snoop_ready, .snoop_req_addr, .snoop_corrupt,
        .cycle_valid, .cycle_addr, .cycle_be, .cycle_parity_error, .parity_error_seen);
    bus_addr_chk bus_addr_chk_inst(.sys_clk, .resetn, .address_wrap_mask_n(pins_if.address_wrap_mask_n),
        .address_float_request(pins_if.address_float_request),
        .external_snoop_strobe_n(pins_if.external_snoop_strobe_n),
        .cycle_start_strobe_n(pins_if.cycle_start_strobe_n), .address_parity_error_n(pins_if.address_parity_error_n),
        .dev_addr_out(pins_if.dev_addr_out), .dev_addr_oe_n(pins_if.dev_addr_oe_n), .dev_ap_out(pins_if.dev_ap_out),
        .dev_ap_oe_n(pins_if.dev_ap_oe_n), .dev_be_out(pins_if.dev_be_out), .dev_be_oe_n(pins_if.dev_be_oe_n),
        .phys_address_bus(pins_if.phys_address_bus), .address_parity_bit(pins_if.address_parity_bit),
        .byte_lane_enable_n(pins_if.byte_lane_enable_n));

    // free-running bus clock
    always #25 sys_clk = ~sys_clk;

    // reporting and compares
    task automatic fail(input string msg);
        err_count++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic bound(input int k, input string msg);
        if (k >= 100) begin
            fail(msg);
            tally_and_finish();
        end
    endtask
    task automatic check_cycle(input logic [ADDR_MSB:ADDR_LSB] ga, ea, input logic [BE_WIDTH-1:0] gb, eb,
        input logic gp);
        check_count++;
        if (ga !== ea || gb !== eb || gp !== 1'b0) fail("cycle seen by system end differs");
    endtask
    task automatic check_snoop(input logic [ADDR_MSB:SNOOP_LSB] g, e);
        check_count++;
        if (g !== e) fail("snoop address differs");
    endtask
    task automatic check_flag(input logic g, e);
        check_count++;
        if (g !== e) fail("flag differs");
    endtask
    task automatic check_strap(input logic ge, ee, input logic [ID_WIDTH-1:0] gi, ei);
        check_count++;
        if (ge !== ee || gi !== ei) fail("strap capture differs");
    endtask

    // bus actions
    task automatic do_reset(input logic en, input logic [ID_WIDTH-1:0] id);
        resetn <= 1'b0;
        strap_irq_enable <= en;
        strap_id <= id;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (straps_valid !== 1'b1 && n < 100);
        bound(n, "straps never valid");
        check_strap(local_irq_ctrl_enable, en, local_irq_ctrl_id, id);
    endtask
    task automatic issue(input logic [ADDR_MSB:ADDR_LSB] ia, input logic [BE_WIDTH-1:0] ib);
        logic [ADDR_MSB:ADDR_LSB] e;
        e = ia;
        if (wrap_on) e[WRAP_BIT] = 1'b0;
        req_valid <= 1'b1;
        req_addr <= ia;
        req_be <= ib;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        bound(n, "request never taken");
        cyc_addr_q.push_back(e);
        cyc_be_q.push_back(ib);
    endtask
    task automatic idle;
        req_valid <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic random_cycles(input int cnt, input logic set20);
        for (int i = 0; i < cnt; i++) begin
            r = $random(seed);
            a = r[ADDR_MSB:ADDR_LSB];
            if (set20) a[WRAP_BIT] = 1'b1;
            r = $random(seed);
            issue(a, r[BE_WIDTH-1:0]);
        end
        idle();
    endtask
    task automatic snoop(input logic [ADDR_MSB:SNOOP_LSB] sa, input logic bad);
        snoop_req <= 1'b1;
        snoop_req_addr <= sa;
        snoop_corrupt <= bad;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (snoop_ready !== 1'b1 && n < 100);
        bound(n, "snoop never taken");
        snp_addr_q.push_back(sa);
        snp_bad_q.push_back(bad);
        perr_sent += bad;
        snoop_req <= 1'b0;
        repeat (7) @(posedge sys_clk);
    endtask
    task automatic drain;
        n = 0;
        while (cyc_addr_q.size() + snp_addr_q.size() != 0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        bound(n, "results missing");
        repeat (8) @(posedge sys_clk);
    endtask

    // watch outputs and match oldest notes
    always @(negedge sys_clk) begin
        if (resetn) begin
            check_flag(snoop_parity_error, perr_due);
            perr_due = 1'b0;
            if (parity_error_seen === 1'b1) perr_seen++;
            if (cycle_valid === 1'b1 && cyc_addr_q.size() == 0) fail("unexpected cycle");
            else if (cycle_valid === 1'b1) check_cycle(cycle_addr, cyc_addr_q.pop_front(), cycle_be,
                cyc_be_q.pop_front(), cycle_parity_error);
            if (snoop_valid === 1'b1 && snp_addr_q.size() == 0) fail("unexpected snoop");
            else if (snoop_valid === 1'b1) begin
                perr_due = snp_bad_q.pop_front();
                check_snoop(snoop_addr, snp_addr_q.pop_front());
            end
        end
    end

    // main sequence
    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        {req_valid, wrap_enable, float_hold, snoop_req, snoop_corrupt, wrap_on, perr_due} = '0;
        req_addr = '0;
        req_be = '0;
        snoop_req_addr = '0;
        {err_count, check_count, perr_sent, perr_seen} = '0;
        seed = 32'h4cb1;
        do_reset(1'b1, 4'ha);
        random_cycles(12, 1'b0);
        for (int k = 0; k < 2; k++) begin
            wrap_enable <= (k == 0); // mask only in modelled real mode
            wrap_on = (k == 0);
            repeat (6) @(posedge sys_clk);
            random_cycles(4, 1'b1);
        end
        float_hold <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check_flag(req_ready, 1'b0);
        check_flag(&pins_if.phys_address_bus, 1'b1);
        float_hold <= 1'b0;
        random_cycles(3, 1'b0);
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            snoop(r[ADDR_MSB:SNOOP_LSB], i[0]);
        end
        random_cycles(4, 1'b0);
        drain();
        do_reset(1'b0, 4'h5);
        random_cycles(3, 1'b0);
        drain();
        check_flag(perr_seen == perr_sent, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
